// [sfsr_pkg.sv]
// Overview of operation
// - 32-sector code 000 none; 001 sector 31; 010 sectors 30-31; 011 sectors 28-31.
// - 32-sector code 100 sectors 24-31; 101 sectors 16-31; 110 and 111 all sectors.
// - 128-sector code 000 none; 001 sectors 126-127; 010 124-127; 011 120-127.
// - 128-sector code 100 112-127; 101 96-127; 110 64-127; 111 all sectors.
// - status read is accepted at any time, even during a self-timed cycle.
// - status bit 0 is busy, one while a write or erase cycle runs.
// - status read repeats the current status byte while select stays low.
// - opcode 01 is write-status; it changes only the protect bits.
// - sectors covered by the protect bits are reported read-only to modifiers.
// - write-status executes only with opcode plus exactly one byte, select rising after.
// - write-status cycle starts at select rise, lasts 5 ms, busy held meanwhile.
// - read is opcode 03 plus 24-bit address, bits taken on rising clock.
// - read data leaves on falling clock edges, most significant bit first.
// - read address steps by one per byte and wraps to zero.
// - a read may start at any byte address.
// - select rising ends a read and data output stops driving.
// - a read arriving during a write or erase cycle is ignored.
// - address bits above the part's capacity are ignored.
// - status bit 1 is the write-enable latch gating write-status.
// - write-enable latch clears when the write-status cycle completes.
// - write-status must end on a byte boundary or it is rejected.
// - opcode 05 is status read, shifting out the status register.
package sfsr_pkg;
  localparam logic [7:0] OP_WRITE_STATUS = 8'h01;
  localparam logic [7:0] OP_READ_BYTES = 8'h03;
  localparam logic [7:0] OP_READ_STATUS = 8'h05;
  localparam int BUSY_BIT = 0;
  localparam int WEL_BIT = 1;
  localparam int PROT_LSB = 2;
  localparam int PROT_MSB = 4;
  localparam logic [2:0] PROT_RESET = 3'h0;
  localparam logic [5:0] CNT_OPCODE_LAST = 6'h07;
  localparam logic [5:0] CNT_WRSR_LAST = 6'h0F;
  localparam logic [5:0] CNT_ADDR_LAST = 6'h1F;
  localparam logic [5:0] CNT_MAX = 6'h3F;
  localparam int ADDR_BITS_DEFAULT = 23;
  localparam int CORE_CLK_MHZ = 100;
  localparam int STATUS_WRITE_CYCLE_TIME_US = 5000;
  localparam int STATUS_WRITE_CYCLES = STATUS_WRITE_CYCLE_TIME_US * CORE_CLK_MHZ;
  localparam logic [7:0] PROT_THR_32 [8] = '{8'h20, 8'h1F, 8'h1E, 8'h1C,
                                             8'h18, 8'h10, 8'h00, 8'h00};
  localparam logic [7:0] PROT_THR_128 [8] = '{8'h80, 8'h7E, 8'h7C, 8'h78,
                                              8'h70, 8'h60, 8'h40, 8'h00};
  typedef enum logic [2:0] {
    SFSR_IDLE = 3'b000,
    SFSR_STAT = 3'b001,
    SFSR_ADDR = 3'b010,
    SFSR_READ = 3'b011,
    SFSR_WRSR = 3'b100,
    SFSR_SKIP = 3'b101
  } sfsr_mode_t;
endpackage : sfsr_pkg

// [sfsr_prot_if.sv]
`timescale 1ns/100ps
`default_nettype none
interface sfsr_prot_if;
  logic [2:0] level;
  logic [6:0] sector;
  logic is_protected;
  modport asker (output level, output sector, input is_protected);
  modport decoder (input level, input sector, output is_protected);
endinterface : sfsr_prot_if
`default_nettype wire

// [sfsr_sync.sv]
`timescale 1ns/100ps
`default_nettype none
module sfsr_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [WIDTH-1:0] d_in,
  output logic [WIDTH-1:0] q_out
);
  logic [WIDTH-1:0] meta_r;

  // meta_r feeds only the second stage
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      meta_r <= '0;
      q_out <= '0;
    end else begin
      meta_r <= d_in;
      q_out <= meta_r;
    end
  end
endmodule : sfsr_sync
`default_nettype wire

// [sfsr_protect.sv]
`timescale 1ns/100ps
`default_nettype none
module sfsr_protect #(
  parameter bit SECTORS_128 = 1'b1
) (
  input wire logic clk_in,
  input wire logic rst_in,
  sfsr_prot_if.decoder prot
);
  import sfsr_pkg::*;

  function automatic logic covered(input logic [2:0] code, input logic [6:0] sector);
    logic [7:0] thr;
    thr = SECTORS_128 ? PROT_THR_128[code] : PROT_THR_32[code];
    return {1'b0, sector} >= thr;
  endfunction : covered

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      prot.is_protected <= 1'b0;
    end else begin
      prot.is_protected <= covered(prot.level, prot.sector);
    end
  end
endmodule : sfsr_protect
`default_nettype wire

// [sfsr_top.sv]
`timescale 1ns/100ps
`default_nettype none
module sfsr_top #(
  parameter int ADDR_BITS = sfsr_pkg::ADDR_BITS_DEFAULT,
  parameter bit SECTORS_128 = 1'b1,
  parameter int unsigned WS_CYCLES = sfsr_pkg::STATUS_WRITE_CYCLES
) (
  input wire logic CORE_CLK_IN,
  input wire logic SYS_RST_IN,
  input wire logic SERIAL_CLOCK_IN,
  input wire logic CHIP_SELECT_LOW_IN,
  input wire logic SERIAL_COMMAND_IN,
  output logic SERIAL_DATA_OUT,
  output logic SERIAL_DATA_OE_N_OUT,
  output logic [23:0] MEM_READ_ADDR_OUT,
  input wire logic [7:0] MEM_READ_DATA_IN,
  input wire logic WEL_SET_IN,
  input wire logic WEL_CLR_IN,
  input wire logic EXT_BUSY_IN,
  input wire logic [2:0] PROTECT_STORED_IN,
  output logic [2:0] PROTECT_LEVEL_OUT,
  output logic PROTECT_STORE_WRITE_OUT,
  output logic [7:0] STATUS_OUT,
  input wire logic [6:0] SECTOR_QUERY_IN,
  output logic SECTOR_PROTECTED_OUT
);
  import sfsr_pkg::*;

  function automatic logic [23:0] cap_addr(input logic [23:0] a);
    logic [23:0] mask;
    mask = 24'hFFFFFF >> (24 - ADDR_BITS);
    return a & mask;
  endfunction : cap_addr

  // ---------------- link side, serial clock ----------------
  // select high clears the frame state; the clock stops between frames
  logic link_rst;
  assign link_rst = CHIP_SELECT_LOW_IN | SYS_RST_IN;

  sfsr_mode_t mode_r;
  sfsr_mode_t mode_nxt;
  logic [5:0] cnt_r;
  logic [2:0] dbit_r;
  logic [7:0] op_r;
  logic [23:0] addr_sh_r;
  logic [23:0] rd_addr_r;
  logic [7:0] wr_sh_r;
  logic [7:0] wrsr_data_r;
  logic wrsr_ok_r;
  logic frame_tag_r;
  logic [7:0] status_link;
  logic [7:0] opcode_full;
  logic [23:0] addr_full;

  assign opcode_full = {op_r[6:0], SERIAL_COMMAND_IN};
  assign addr_full = {addr_sh_r[22:0], SERIAL_COMMAND_IN};

  always_comb begin
    mode_nxt = mode_r;
    case (mode_r)
      SFSR_IDLE: begin
        if (cnt_r == CNT_OPCODE_LAST) begin
          if (opcode_full == OP_READ_STATUS) begin
            mode_nxt = SFSR_STAT;
          end else if (opcode_full == OP_READ_BYTES && !status_link[BUSY_BIT]) begin
            mode_nxt = SFSR_ADDR;
          end else if (opcode_full == OP_WRITE_STATUS) begin
            mode_nxt = SFSR_WRSR;
          end else begin
            mode_nxt = SFSR_SKIP;
          end
        end
      end
      SFSR_ADDR: begin
        if (cnt_r == CNT_ADDR_LAST) begin
          mode_nxt = SFSR_READ;
        end
      end
      SFSR_STAT, SFSR_READ, SFSR_WRSR, SFSR_SKIP: mode_nxt = mode_r;
      default: mode_nxt = SFSR_SKIP;
    endcase
  end

  always_ff @(posedge SERIAL_CLOCK_IN or posedge link_rst) begin
    if (link_rst) begin
      mode_r <= SFSR_IDLE;
    end else begin
      mode_r <= mode_nxt;
    end
  end

  always_ff @(posedge SERIAL_CLOCK_IN or posedge link_rst) begin
    if (link_rst) begin
      cnt_r <= 6'h00;
    end else if (cnt_r != CNT_MAX) begin
      cnt_r <= cnt_r + 6'h01;
    end
  end

  // every opcode and address bit is taken on the rising edge
  always_ff @(posedge SERIAL_CLOCK_IN or posedge link_rst) begin
    if (link_rst) begin
      op_r <= 8'h00;
      addr_sh_r <= 24'h000000;
      wr_sh_r <= 8'h00;
    end else begin
      if (mode_r == SFSR_IDLE) begin
        op_r <= opcode_full;
      end
      if (mode_r == SFSR_ADDR) begin
        addr_sh_r <= addr_full;
      end
      if (mode_r == SFSR_WRSR) begin
        wr_sh_r <= {wr_sh_r[6:0], SERIAL_COMMAND_IN};
      end
    end
  end

  // data phase bit index and auto-incrementing read address
  always_ff @(posedge SERIAL_CLOCK_IN or posedge link_rst) begin
    if (link_rst) begin
      dbit_r <= 3'h0;
      rd_addr_r <= 24'h000000;
    end else if (mode_r == SFSR_ADDR && cnt_r == CNT_ADDR_LAST) begin
      dbit_r <= 3'h0;
      rd_addr_r <= cap_addr(addr_full);
    end else if (mode_r == SFSR_READ || mode_r == SFSR_STAT) begin
      dbit_r <= dbit_r + 3'h1;
      if (mode_r == SFSR_READ && dbit_r == 3'h7) begin
        rd_addr_r <= cap_addr(rd_addr_r + 24'h000001);
      end
    end
  end

  assign MEM_READ_ADDR_OUT = rd_addr_r;

  // these survive select rising so the core side can judge the frame
  always_ff @(posedge SERIAL_CLOCK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      wrsr_ok_r <= 1'b0;
      wrsr_data_r <= 8'h00;
      frame_tag_r <= 1'b0;
    end else begin
      // true only if the last edge of the frame was the sixteenth
      wrsr_ok_r <= (mode_r == SFSR_WRSR) && (cnt_r == CNT_WRSR_LAST);
      if (mode_r == SFSR_WRSR && cnt_r == CNT_WRSR_LAST) begin
        wrsr_data_r <= {wr_sh_r[6:0], SERIAL_COMMAND_IN};
      end
      if (cnt_r == 6'h00) begin
        frame_tag_r <= ~frame_tag_r;
      end
    end
  end

  // output shifts on the falling edge, msb first
  always_ff @(negedge SERIAL_CLOCK_IN or posedge link_rst) begin
    if (link_rst) begin
      SERIAL_DATA_OUT <= 1'b0;
      SERIAL_DATA_OE_N_OUT <= 1'b1;
    end else if (mode_r == SFSR_READ) begin
      SERIAL_DATA_OUT <= MEM_READ_DATA_IN[~dbit_r];
      SERIAL_DATA_OE_N_OUT <= 1'b0;
    end else if (mode_r == SFSR_STAT) begin
      // the byte repeats and tracks live status bit by bit, so a change can show mid-byte
      SERIAL_DATA_OUT <= status_link[~dbit_r];
      SERIAL_DATA_OE_N_OUT <= 1'b0;
    end else begin
      SERIAL_DATA_OUT <= 1'b0;
      SERIAL_DATA_OE_N_OUT <= 1'b1;
    end
  end

  // ---------------- core side ----------------
  logic [7:0] status_r;
  logic [2:0] prot_r;
  logic [2:0] prot_pend_r;
  logic wel_r;
  logic ws_busy_r;
  logic [31:0] ws_cnt_r;
  logic loaded_r;
  logic cs_act_s;
  logic cs_act_d_r;
  logic last_tag_r;
  logic [9:0] link_flags_s;
  logic cs_rise;
  logic ws_start;
  logic ws_done;

  // synced as select-active so its reset value matches the idle pin
  sfsr_sync #(.WIDTH(1)) u_cs_sync (
    .clk_in(CORE_CLK_IN),
    .rst_in(SYS_RST_IN),
    .d_in(~CHIP_SELECT_LOW_IN),
    .q_out(cs_act_s)
  );

  // data and tag are stable well before select rises, same depth as select
  sfsr_sync #(.WIDTH(10)) u_flag_sync (
    .clk_in(CORE_CLK_IN),
    .rst_in(SYS_RST_IN),
    .d_in({frame_tag_r, wrsr_ok_r, wrsr_data_r}),
    .q_out(link_flags_s)
  );

  sfsr_sync #(.WIDTH(8)) u_status_sync (
    .clk_in(SERIAL_CLOCK_IN),
    .rst_in(SYS_RST_IN),
    .d_in(status_r),
    .q_out(status_link)
  );

  always_ff @(posedge CORE_CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      cs_act_d_r <= 1'b0;
      last_tag_r <= 1'b0;
    end else begin
      cs_act_d_r <= cs_act_s;
      if (cs_rise) begin
        last_tag_r <= link_flags_s[9];
      end
    end
  end

  assign cs_rise = ~cs_act_s & cs_act_d_r;
  // a frame with no clocks leaves the tag unchanged and runs nothing
  assign ws_start = cs_rise && link_flags_s[8] && (link_flags_s[9] != last_tag_r)
                    && wel_r && !status_r[BUSY_BIT];
  assign ws_done = ws_busy_r && (ws_cnt_r == WS_CYCLES - 32'd1);

  // self-timed status-write cycle
  always_ff @(posedge CORE_CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      ws_busy_r <= 1'b0;
      ws_cnt_r <= 32'h00000000;
      prot_pend_r <= PROT_RESET;
    end else if (ws_start) begin
      ws_busy_r <= 1'b1;
      ws_cnt_r <= 32'h00000000;
      prot_pend_r <= link_flags_s[PROT_MSB:PROT_LSB];
    end else if (ws_done) begin
      ws_busy_r <= 1'b0;
    end else if (ws_busy_r) begin
      ws_cnt_r <= ws_cnt_r + 32'h00000001;
    end
  end

  // protect bits: restored from the store after reset, updated at cycle end
  always_ff @(posedge CORE_CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      prot_r <= PROT_RESET;
      loaded_r <= 1'b0;
      PROTECT_STORE_WRITE_OUT <= 1'b0;
    end else begin
      loaded_r <= 1'b1;
      PROTECT_STORE_WRITE_OUT <= ws_done;
      if (!loaded_r) begin
        prot_r <= PROTECT_STORED_IN;
      end else if (ws_done) begin
        prot_r <= prot_pend_r;
      end
    end
  end

  // a set arriving with a clear wins
  always_ff @(posedge CORE_CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      wel_r <= 1'b0;
    end else if (WEL_SET_IN) begin
      wel_r <= 1'b1;
    end else if (WEL_CLR_IN || ws_done) begin
      wel_r <= 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      status_r <= 8'h00;
    end else begin
      status_r <= 8'h00;
      status_r[BUSY_BIT] <= ws_busy_r | ws_start | EXT_BUSY_IN;
      status_r[WEL_BIT] <= wel_r;
      status_r[PROT_MSB:PROT_LSB] <= prot_r;
    end
  end

  assign STATUS_OUT = status_r;
  assign PROTECT_LEVEL_OUT = prot_r;

  sfsr_prot_if prot_bus ();
  assign prot_bus.level = prot_r;
  assign prot_bus.sector = SECTOR_QUERY_IN;
  assign SECTOR_PROTECTED_OUT = prot_bus.is_protected;

  sfsr_protect #(.SECTORS_128(SECTORS_128)) u_protect (
    .clk_in(CORE_CLK_IN),
    .rst_in(SYS_RST_IN),
    .prot(prot_bus.decoder)
  );
endmodule : sfsr_top
`default_nettype wire

// [sfsr_top_chk.sv]
`timescale 1ns/100ps
`default_nettype none
module sfsr_top_chk #(
  parameter int ADDR_BITS = 23,
  parameter bit SECTORS_128 = 1'b1,
  parameter int unsigned WS_CYCLES = 50
) (
  input wire logic CORE_CLK_IN,
  input wire logic SYS_RST_IN,
  input wire logic SERIAL_CLOCK_IN,
  input wire logic CHIP_SELECT_LOW_IN,
  input wire logic EXT_BUSY_IN,
  input wire logic WEL_SET_IN,
  input wire logic SERIAL_DATA_OUT,
  input wire logic SERIAL_DATA_OE_N_OUT,
  input wire logic [23:0] MEM_READ_ADDR_OUT,
  input wire logic [2:0] PROTECT_LEVEL_OUT,
  input wire logic PROTECT_STORE_WRITE_OUT,
  input wire logic [7:0] STATUS_OUT,
  input wire logic [6:0] SECTOR_QUERY_IN,
  input wire logic SECTOR_PROTECTED_OUT
);
  int busy_cnt;
  logic ext_seen;
  function automatic int thr(logic [2:0] c);
    if (SECTORS_128) return (c == 3'h0) ? 128 : 128 - (1 << c);
    return (c == 3'h0) ? 32 : (c >= 3'h6) ? 0 : 32 - (1 << (c - 3'h1));
  endfunction : thr
  always_ff @(posedge CORE_CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) busy_cnt <= 0;
    else busy_cnt <= STATUS_OUT[0] ? busy_cnt + 1 : 0;
  end
  // an outside busy stretches the span, so such spans are not measured
  always_ff @(posedge CORE_CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) ext_seen <= 1'b0;
    else ext_seen <= STATUS_OUT[0] ? (ext_seen | EXT_BUSY_IN) : 1'b0;
  end
  chk_status_prot:
    assert property (@(posedge CORE_CLK_IN) disable iff (SYS_RST_IN)
      STATUS_OUT[4:2] == $past(PROTECT_LEVEL_OUT) && STATUS_OUT[7:5] == 3'h0)
    else $error("status protect field wrong");
  chk_prot_cause:
    assert property (@(posedge CORE_CLK_IN) disable iff (SYS_RST_IN)
      $changed(PROTECT_LEVEL_OUT) && !$past(SYS_RST_IN) && !$past(SYS_RST_IN, 2)
      |-> PROTECT_STORE_WRITE_OUT)
    else $error("protect bits changed without store");
  chk_store_pulse:
    assert property (@(posedge CORE_CLK_IN) disable iff (SYS_RST_IN)
      PROTECT_STORE_WRITE_OUT |-> STATUS_OUT[0] ##1 !PROTECT_STORE_WRITE_OUT)
    else $error("store pulse outside busy or too long");
  chk_wel_done:
    assert property (@(posedge CORE_CLK_IN) disable iff (SYS_RST_IN)
      PROTECT_STORE_WRITE_OUT && !EXT_BUSY_IN && !WEL_SET_IN |-> ##[1:3] STATUS_OUT[1:0] == 2'h0)
    else $error("latch or busy left set after cycle");
  chk_busy_span:
    assert property (@(posedge CORE_CLK_IN) disable iff (SYS_RST_IN)
      $fell(STATUS_OUT[0]) && !ext_seen |-> busy_cnt >= WS_CYCLES && busy_cnt <= WS_CYCLES + 2)
    else $error("busy span wrong");
  chk_ext_busy:
    assert property (@(posedge CORE_CLK_IN) disable iff (SYS_RST_IN)
      EXT_BUSY_IN [*3] |-> STATUS_OUT[0])
    else $error("outside busy not reported");
  chk_sector_map:
    assert property (@(posedge CORE_CLK_IN) disable iff (SYS_RST_IN)
      SECTOR_PROTECTED_OUT == ($past(SECTOR_QUERY_IN) >= thr($past(PROTECT_LEVEL_OUT))))
    else $error("sector protect answer wrong");
  chk_oe_off:
    assert property (@(posedge CORE_CLK_IN) disable iff (SYS_RST_IN)
      CHIP_SELECT_LOW_IN |-> SERIAL_DATA_OE_N_OUT && !SERIAL_DATA_OUT)
    else $error("data driven while deselected");
  chk_addr_cap:
    assert property (@(posedge CORE_CLK_IN) disable iff (SYS_RST_IN)
      (MEM_READ_ADDR_OUT >> ADDR_BITS) == 24'h0)
    else $error("address above capacity");
  chk_addr_step:
    assert property (@(posedge SERIAL_CLOCK_IN) disable iff (SYS_RST_IN || CHIP_SELECT_LOW_IN)
      $changed(MEM_READ_ADDR_OUT) && !SERIAL_DATA_OE_N_OUT && !$past(SERIAL_DATA_OE_N_OUT)
      |-> MEM_READ_ADDR_OUT == 24'(($past(MEM_READ_ADDR_OUT) + 1) & ((1 << ADDR_BITS) - 1)))
    else $error("read address step wrong");
  cov_store: cover property (@(posedge CORE_CLK_IN) PROTECT_STORE_WRITE_OUT);
  cov_ext: cover property (@(posedge CORE_CLK_IN) EXT_BUSY_IN && STATUS_OUT[0]);
  cov_wrap: cover property (@(posedge SERIAL_CLOCK_IN)
    MEM_READ_ADDR_OUT == 24'h0 && !SERIAL_DATA_OE_N_OUT);
endmodule : sfsr_top_chk
bind sfsr_top sfsr_top_chk #(.ADDR_BITS(ADDR_BITS), .SECTORS_128(SECTORS_128),
  .WS_CYCLES(WS_CYCLES)) u_chk (.CORE_CLK_IN, .SYS_RST_IN, .SERIAL_CLOCK_IN,
  .CHIP_SELECT_LOW_IN, .EXT_BUSY_IN, .WEL_SET_IN, .SERIAL_DATA_OUT, .SERIAL_DATA_OE_N_OUT,
  .MEM_READ_ADDR_OUT, .PROTECT_LEVEL_OUT, .PROTECT_STORE_WRITE_OUT, .STATUS_OUT,
  .SECTOR_QUERY_IN, .SECTOR_PROTECTED_OUT);
`default_nettype wire

// [sfsr_host.sv]
`timescale 1ns/100ps
`default_nettype none
module sfsr_host (
  output logic sclk,
  output logic cs_n,
  output logic mosi,
  input wire logic miso,
  input wire logic oe_n
);
  localparam realtime HALF = 62.5; // 8 MHz, under the read limit
  // rx keeps bits in arrival order; raw image bytes are read msb first
  logic [63:0] rx;
  logic drove;
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end
  // clock stands low between frames; frames close after nbits clocks, mid-byte when nbits is not a multiple of 8
  task automatic xfer(input int nbits, input logic [63:0] tx);
    rx = '0;
    drove = 1'b0;
    cs_n = 1'b0;
    for (int i = nbits - 1; i >= 0; i--) begin
      mosi = tx[i];
      #HALF sclk = 1'b1;
      rx = {rx[62:0], miso};
      drove = drove | !oe_n;
      #HALF sclk = 1'b0;
    end
    #HALF cs_n = 1'b1;
    mosi = ~mosi; // no stale level once released
    #200;
  endtask : xfer
endmodule : sfsr_host
`default_nettype wire

// [test_serial_flash_status_and_read.sv]
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, exp, got) begin comparisons++; if ((got) !== (exp)) begin fail_count++; \
  $display("BAD %s exp %h got %h", nm, exp, got); end end
module test_serial_flash_status_and_read;
  import sfsr_pkg::*;
  localparam int unsigned WS = 3000;
  logic clk, rst, sclk, cs_n, mosi, miso, oe_n, wel_set, wel_clr, ext_busy, prot_q;
  logic [23:0] maddr;
  logic [7:0] status;
  logic [2:0] prot_lvl;
  logic [6:0] sector;
  int fail_count = 0;
  int comparisons = 0;
  int cycles = 0;
  function automatic logic [7:0] mem(logic [23:0] a);
    return a[7:0] ^ a[22:15];
  endfunction : mem
  function automatic int thr(int c);
    return (c == 0) ? 128 : 128 - (1 << c);
  endfunction : thr
  sfsr_top #(.WS_CYCLES(WS)) dut (.CORE_CLK_IN(clk), .SYS_RST_IN(rst), .SERIAL_CLOCK_IN(sclk),
    .CHIP_SELECT_LOW_IN(cs_n), .SERIAL_COMMAND_IN(mosi), .SERIAL_DATA_OUT(miso),
    .SERIAL_DATA_OE_N_OUT(oe_n), .MEM_READ_ADDR_OUT(maddr), .MEM_READ_DATA_IN(mem(maddr)),
    .WEL_SET_IN(wel_set), .WEL_CLR_IN(wel_clr), .EXT_BUSY_IN(ext_busy),
    .PROTECT_STORED_IN(3'h5), .PROTECT_LEVEL_OUT(prot_lvl), .PROTECT_STORE_WRITE_OUT(),
    .STATUS_OUT(status), .SECTOR_QUERY_IN(sector), .SECTOR_PROTECTED_OUT(prot_q));
  sfsr_host host (.sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso), .oe_n(oe_n));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic pulse(ref logic p);
    @(negedge clk) p = 1'b1;
    @(negedge clk) p = 1'b0;
    repeat (2) @(negedge clk);
  endtask : pulse
  task automatic wrap_up();
    if (fail_count == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : wrap_up
  always @(posedge clk) begin
    cycles++;
    if (cycles == 80000) begin
      fail_count++;
      wrap_up();
    end
  end
  initial begin
    rst = 1'b1; wel_set = 1'b0; wel_clr = 1'b0; ext_busy = 1'b0; sector = 7'h00;
    repeat (10) @(negedge clk);
    rst = 1'b0;
    repeat (6) @(negedge clk);
    `CHK("stored prot", 8'h14, status)
    host.xfer(24, 64'h050000);
    `CHK("status twice", 16'h1414, host.rx[15:0])
    host.xfer(16, 64'h0100);
    `CHK("no latch", 8'h14, status)
    pulse(wel_set);
    `CHK("latch set", 8'h16, status)
    pulse(wel_clr);
    `CHK("latch clear", 8'h14, status)
    pulse(wel_set);
    host.xfer(24, 64'h010000); // two data bytes
    host.xfer(12, 64'h010); // ends mid-byte
    `CHK("bad frames", 8'h16, status)
    ext_busy = 1'b1;
    repeat (4) @(negedge clk);
    `CHK("outside busy", 1'b1, status[0])
    host.xfer(40, 64'h03_000000_00);
    `CHK("read refused", 1'b0, host.drove)
    ext_busy = 1'b0;
    for (int c = 0; c < 8; c++) begin
      pulse(wel_set); // latch before every status write
      host.xfer(16, {48'h0, 8'h01, 3'h7, c[2:0], 2'h3});
      host.xfer(24, 64'h050000);
      `CHK("busy read", 2'h3, host.rx[1:0])
      host.xfer(40, 64'h03_000000_00);
      `CHK("read in cycle", 1'b0, host.drove)
      repeat (5000) begin // wait out the cycle by polling busy
        @(negedge clk);
        if (status[0] === 1'b0) break;
      end
      repeat (2) @(negedge clk);
      `CHK("prot code", c[2:0], prot_lvl)
      `CHK("status after", {3'h0, c[2:0], 2'h0}, status)
      for (int s = 0; s < 128; s++) begin
        sector = s[6:0];
        @(negedge clk);
        `CHK("sector", s >= thr(c), prot_q)
      end
    end
    host.xfer(64, {8'h03, 24'hFFFFFE, 32'h0});
    `CHK("stream", {mem(24'h7FFFFE), mem(24'h7FFFFF), mem(24'h0), mem(24'h1)}, host.rx[31:0])
    host.xfer(36, {8'h03, 24'h123457, 4'h0});
    `CHK("part byte", mem(24'h123457) >> 4, host.rx[7:0])
    `CHK("released", 1'b1, oe_n)
    wrap_up();
  end
endmodule : test_serial_flash_status_and_read
`default_nettype wire
